// ===== design/two_level_interrupt_controller.sv
// Two-level priority interrupt controller with AXI4-Lite register access
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`include "irq_ctrl_defines.svh"
module two_level_interrupt_controller (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 srst,
  // AXI4-Lite write address and data
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Event sources
  input  wire logic                 timer_overflow,
  input  wire logic [2:0]           ext_pin,
  input  wire logic [6:0]           port_pin,
  input  wire logic                 port_read,
  input  wire logic                 periph_pending,
  // Pin direction for pull-up control
  input  wire logic [6:0]           port_is_input,
  output logic [6:0]                port_pullup_on,
  // Core sequencer
  input  wire logic                 return_from_service,
  input  wire logic [15:0]          return_addr,
  output irq_ctrl_pkg::vec_req_t    vec_out,
  output logic [15:0]               stack_push_data
);
  import irq_ctrl_pkg::*;

  logic [7:0]  mainQ;        // Main control/flag register
  logic [7:0]  edgePrioQ;    // Edge select and priority
  logic [7:0]  extPinsQ;     // Pins 1 and 2 bits
  logic        prioModeQ;    // Priority mode enable
  logic [6:0]  pullEnQ;      // Per-pin pull-up enables
  logic [6:0]  changeEnQ;    // Per-pin change enables
  level_t      activeQ;      // Highest routine in progress
  logic        lowInSvcQ;    // Low routine interrupted by high
  logic        wasCompatQ;   // Mode at last entry
  logic [2:0]  extS1Q;       // Sync stage 1, external pins
  logic [2:0]  extS2Q;       // Sync stage 2
  logic [2:0]  extPrevQ;     // Previous synchronised level
  logic [6:0]  portS1Q;
  logic [6:0]  portS2Q;
  logic [6:0]  portLatchQ;   // Level latched at last port read
  vec_req_t    vecQ;
  logic [15:0] pushQ;

  // Bus handshake state
  logic        awHeldQ, wHeldQ;
  logic [11:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0]  wStrbQ;
  logic        bValidQ, rValidQ;
  logic [31:0] rDataQ;
  logic [1:0]  bRespQ, rRespQ;

  // Synchronisers run through reset so a pin idling high gives no false edge
  always_ff @(posedge clk)
  begin
    extS1Q   <= ext_pin;
    extS2Q   <= extS1Q;
    extPrevQ <= extS2Q;
    portS1Q  <= port_pin;
    portS2Q  <= portS1Q;
  end

  // Edge detection per selected polarity
  logic [2:0] edgeSel;
  logic [2:0] extEvent;
  assign edgeSel  = {edgePrioQ[`B_EDG2], edgePrioQ[`B_EDG1], edgePrioQ[`B_EDG0]};
  assign extEvent = (edgeSel & extS2Q & ~extPrevQ)
                  | (~edgeSel & ~extS2Q & extPrevQ);

  // Mismatch against latched port level, gated per pin
  logic portMismatch;
  assign portMismatch = |((portS2Q ^ portLatchQ) & changeEnQ);

  // Port read ends the mismatch by relatching
  always_ff @(posedge clk)
  begin
    if (srst)
      portLatchQ <= 7'h00;
    else if (port_read)
      portLatchQ <= portS2Q;
  end

  // Pull-ups only on input pins with their enable, unless all disabled
  assign port_pullup_on = edgePrioQ[`B_PU_DIS] ? 7'h00 : (pullEnQ & port_is_input);

  // Bus write decode
  logic       wrFire;
  logic [7:0] wrByte;
  logic       wrOk;
  assign wrFire = awHeldQ && wHeldQ && !bValidQ;
  assign wrByte = wDataQ[7:0];
  assign wrOk   = wStrbQ[0];

  // Request evaluation
  logic tmrReq, x0Req, x1Req, x2Req, pcReq;
  assign tmrReq = mainQ[`B_TMR_F] & mainQ[`B_TMR_IE];
  assign x0Req  = mainQ[`B_X0_F] & mainQ[`B_X0_IE];
  assign x1Req  = extPinsQ[`B_X1_F] & extPinsQ[`B_X1_IE];
  assign x2Req  = extPinsQ[`B_X2_F] & extPinsQ[`B_X2_IE];
  assign pcReq  = mainQ[`B_PC_F] & mainQ[`B_PC_IE];

  logic hiReq, loReq, coreReq, takeHi, takeLo, takeCompat;
  // Priority bit 1 means high; x0 is always high
  assign hiReq = (tmrReq & edgePrioQ[`B_TMR_P]) | (pcReq & edgePrioQ[`B_PC_P])
               | (x1Req & extPinsQ[`B_X1_P]) | (x2Req & extPinsQ[`B_X2_P]) | x0Req;
  assign loReq = (tmrReq & ~edgePrioQ[`B_TMR_P]) | (pcReq & ~edgePrioQ[`B_PC_P])
               | (x1Req & ~extPinsQ[`B_X1_P]) | (x2Req & ~extPinsQ[`B_X2_P])
               | periph_pending;
  assign coreReq = tmrReq | x0Req | x1Req | x2Req | pcReq;
  // Compatibility: global blocks all, peripheral enable gates peripherals
  assign takeCompat = !prioModeQ && mainQ[`B_GIE_H]
                    && (coreReq || (periph_pending && mainQ[`B_PEIE_L]));
  // High passes on high global, even during a low routine
  assign takeHi = prioModeQ && mainQ[`B_GIE_H] && hiReq && (activeQ != LVL_HIGH);
  // Low needs both globals and no routine in progress; high wins ties
  assign takeLo = prioModeQ && mainQ[`B_GIE_H] && mainQ[`B_PEIE_L] && loReq
                && !takeHi && (activeQ == LVL_NONE);

  // Main register: set wins over software clear
  always_ff @(posedge clk)
  begin
    if (srst)
      mainQ <= `RST_MAIN;
    else
    begin
      if (wrFire && wrOk && awAddrQ == `ADDR_MAIN)
        mainQ <= wrByte;
      if (takeCompat || takeHi)
        mainQ[`B_GIE_H] <= 1'b0;
      else if (takeLo)
        mainQ[`B_PEIE_L] <= 1'b0;
      else if (return_from_service && activeQ != LVL_NONE)
      begin
        // Restore whichever enable entry cleared
        if (wasCompatQ || activeQ == LVL_HIGH)
          mainQ[`B_GIE_H] <= 1'b1;
        else
          mainQ[`B_PEIE_L] <= 1'b1;
      end
      if (timer_overflow)
        mainQ[`B_TMR_F] <= 1'b1;
      if (extEvent[0])
        mainQ[`B_X0_F] <= 1'b1;
      if (portMismatch)
        mainQ[`B_PC_F] <= 1'b1;
    end
  end

  // Edge/priority register; unimplemented bits stay zero
  always_ff @(posedge clk)
  begin
    if (srst)
      edgePrioQ <= `RST_EDGE_PRIO;
    else if (wrFire && wrOk && awAddrQ == `ADDR_EDGE_PRIO)
      edgePrioQ <= wrByte & `MASK_EDGE_PRIO;
  end

  // External pins 1 and 2 register
  always_ff @(posedge clk)
  begin
    if (srst)
      extPinsQ <= `RST_EXT_PINS;
    else
    begin
      if (wrFire && wrOk && awAddrQ == `ADDR_EXT_PINS)
        extPinsQ <= wrByte & `MASK_EXT_PINS;
      if (extEvent[1])
        extPinsQ[`B_X1_F] <= 1'b1;
      if (extEvent[2])
        extPinsQ[`B_X2_F] <= 1'b1;
    end
  end

  // Mode, pull-up and change enable registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prioModeQ <= 1'b0;
      pullEnQ   <= 7'h00;
      changeEnQ <= 7'h00;
    end
    else if (wrFire && wrOk)
    begin
      if (awAddrQ == `ADDR_MODE)
        prioModeQ <= wrByte[0];
      if (awAddrQ == `ADDR_PULL_EN)
        pullEnQ <= wrByte[6:0];
      if (awAddrQ == `ADDR_CHANGE_EN)
        changeEnQ <= wrByte[6:0];
    end
  end

  // Service level tracking; one nesting step only
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      activeQ    <= LVL_NONE;
      lowInSvcQ  <= 1'b0;
      wasCompatQ <= 1'b1;
    end
    else if (takeCompat)
    begin
      activeQ    <= LVL_HIGH;
      wasCompatQ <= 1'b1;
    end
    else if (takeHi)
    begin
      lowInSvcQ  <= (activeQ == LVL_LOW);
      activeQ    <= LVL_HIGH;
      wasCompatQ <= 1'b0;
    end
    else if (takeLo)
    begin
      activeQ    <= LVL_LOW;
      wasCompatQ <= 1'b0;
    end
    else if (return_from_service)
    begin
      activeQ   <= lowInSvcQ ? LVL_LOW : LVL_NONE;
      lowInSvcQ <= 1'b0;
    end
  end

  // Vector and stack push; sync adds two cycles, flag a third, vector a fourth
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      vecQ  <= '0;
      pushQ <= 16'h0000;
    end
    else
    begin
      vecQ.push   <= takeCompat || takeHi || takeLo;
      vecQ.high   <= takeCompat || takeHi;
      vecQ.vector <= takeLo ? `VEC_LOW : `VEC_HIGH;
      pushQ       <= return_addr;
    end
  end
  assign vec_out         = vecQ;
  assign stack_push_data = pushQ;

  // AXI write channels, either order
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      awHeldQ <= 1'b0;
      wHeldQ  <= 1'b0;
      awAddrQ <= 12'h000;
      wDataQ  <= 32'h0000_0000;
      wStrbQ  <= 4'h0;
      bValidQ <= 1'b0;
      bRespQ  <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeldQ <= 1'b1;
        awAddrQ <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeldQ <= 1'b1;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (wrFire)
      begin
        awHeldQ <= 1'b0;
        wHeldQ  <= 1'b0;
        bValidQ <= 1'b1;
        // Unmapped or status writes get SLVERR
        bRespQ  <= (awAddrQ < `ADDR_STATUS) ? 2'h0 : 2'h2;
      end
      else if (bValidQ && s_axi_bready)
        bValidQ <= 1'b0;
    end
  end
  assign s_axi_awready = !awHeldQ && !bValidQ;
  assign s_axi_wready  = !wHeldQ && !bValidQ;
  assign s_axi_bvalid  = bValidQ;
  assign s_axi_bresp   = bRespQ;

  // AXI read, one cycle after address
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rValidQ <= 1'b0;
      rDataQ  <= 32'h0000_0000;
      rRespQ  <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rValidQ <= 1'b1;
      rRespQ  <= 2'h0;
      case ({s_axi_araddr[11:2], 2'h0})
        `ADDR_MAIN:      rDataQ <= {24'h000000, mainQ};
        `ADDR_EDGE_PRIO: rDataQ <= {24'h000000, edgePrioQ};
        `ADDR_EXT_PINS:  rDataQ <= {24'h000000, extPinsQ};
        `ADDR_MODE:      rDataQ <= {31'h00000000, prioModeQ};
        `ADDR_PULL_EN:   rDataQ <= {25'h0000000, pullEnQ};
        `ADDR_CHANGE_EN: rDataQ <= {25'h0000000, changeEnQ};
        `ADDR_STATUS:    rDataQ <= {29'h00000000, lowInSvcQ, activeQ};
        default:
        begin
          rDataQ <= 32'h0000_0000;
          rRespQ <= 2'h2;
        end
      endcase
    end
    else if (rValidQ && s_axi_rready)
      rValidQ <= 1'b0;
  end
  assign s_axi_arready = !rValidQ;
  assign s_axi_rvalid  = rValidQ;
  assign s_axi_rdata   = rDataQ;
  assign s_axi_rresp   = rRespQ;
  // Checks on what the core and software see; vector, flag and enable checks one cycle after the cause
  AST_VEC_LOW: assert property (@(posedge clk) disable iff (srst)
    takeLo |=> vecQ.push && vecQ.vector == `VEC_LOW) else $error("low vector wrong");
  AST_VEC_COMPAT: assert property (@(posedge clk) disable iff (srst)
    takeCompat |=> vecQ.vector == `VEC_HIGH && vecQ.high) else $error("compat vector wrong");
  AST_PREEMPT: assert property (@(posedge clk) disable iff (srst)
    (activeQ == LVL_LOW && prioModeQ && mainQ[`B_GIE_H] && hiReq) |=> vecQ.push && vecQ.high
    && activeQ == LVL_HIGH && lowInSvcQ) else $error("high did not preempt");
  AST_GIE_BLOCK: assert property (@(posedge clk) disable iff (srst)
    !mainQ[`B_GIE_H] |-> !(takeCompat || takeHi || takeLo)) else $error("taken while off");
  AST_NO_LOW_IN_HIGH: assert property (@(posedge clk) disable iff (srst)
    activeQ == LVL_HIGH |-> !takeLo) else $error("low taken in high");
  AST_CLR_ENABLE: assert property (@(posedge clk) disable iff (srst)
    takeHi |=> !mainQ[`B_GIE_H]) else $error("high global not cleared");
  AST_CLR_LOW: assert property (@(posedge clk) disable iff (srst)
    takeLo |=> !mainQ[`B_PEIE_L] && activeQ == LVL_LOW) else $error("low global not cleared");
  AST_TIE_HIGH: assert property (@(posedge clk) disable iff (srst)
    (prioModeQ && mainQ[`B_GIE_H] && mainQ[`B_PEIE_L] && hiReq && loReq && activeQ == LVL_NONE)
    |=> vecQ.push && vecQ.high && vecQ.vector == `VEC_HIGH) else $error("low beat high");
  AST_FLAG_SET: assert property (@(posedge clk) disable iff (srst)
    timer_overflow |=> mainQ[`B_TMR_F]) else $error("timer flag not set");
  AST_PC_SET: assert property (@(posedge clk) disable iff (srst)
    portMismatch |=> mainQ[`B_PC_F]) else $error("port flag not set");
  AST_PULLUP: assert property (@(posedge clk) disable iff (srst)
    edgePrioQ[`B_PU_DIS] |-> port_pullup_on == 7'h00) else $error("pull-up not off");
  COV_HIGH: cover property (@(posedge clk) disable iff (srst) takeHi);
  COV_LOW: cover property (@(posedge clk) disable iff (srst) takeLo);
  COV_NEST: cover property (@(posedge clk) disable iff (srst) takeHi && activeQ == LVL_LOW);
endmodule

// ===== design/irq_ctrl_defines.svh
// Register offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_DEFINES_SVH
`define ADDR_MAIN        12'h000
`define ADDR_EDGE_PRIO   12'h004
`define ADDR_EXT_PINS    12'h008
`define ADDR_MODE        12'h00C
`define ADDR_PULL_EN     12'h010
`define ADDR_CHANGE_EN   12'h014
`define ADDR_STATUS      12'h018
`define RST_MAIN         8'h00
`define RST_EDGE_PRIO    8'hF5
`define RST_EXT_PINS     8'hC0
`define MASK_EDGE_PRIO   8'hF5
`define MASK_EXT_PINS    8'hDB
`define VEC_HIGH         16'h0008
`define VEC_LOW          16'h0018
`define SYNC_CYCLES      2
`define B_GIE_H   7
`define B_PEIE_L  6
`define B_TMR_IE  5
`define B_X0_IE   4
`define B_PC_IE   3
`define B_TMR_F   2
`define B_X0_F    1
`define B_PC_F    0
`define B_PU_DIS  7
`define B_EDG0    6
`define B_EDG1    5
`define B_EDG2    4
`define B_TMR_P   2
`define B_PC_P    0
`define B_X2_P    7
`define B_X1_P    6
`define B_X2_IE   4
`define B_X1_IE   3
`define B_X2_F    1
`define B_X1_F    0
`endif

// ===== design/irq_ctrl_pkg.sv
// Types shared by the interrupt controller
package irq_ctrl_pkg;
  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_LOW  = 2'b01,
    LVL_HIGH = 2'b10
  } level_t;
  typedef struct packed {
    logic        push;
    logic [15:0] vector;
    logic        high;
  } vec_req_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } wr_req_t;
endpackage

// ===== testbench/core_model.sv
// Core sequencer model: return address supply, return pulse, push count
module core_model (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // Controller side
  input  wire irq_ctrl_pkg::vec_req_t vecIn,
  output logic                        return_from_service,
  output logic [15:0]                 return_addr,
  // Bench side
  input  wire logic                   retReq,
  output int                          pushCount
);
  timeunit 1ns;
  timeprecision 1ns;
  import irq_ctrl_pkg::*;
  // Return runs one cycle after the bench asks, as the core would
  always_ff @(posedge clk)
  begin
    if (srst)
      return_from_service <= 1'b0;
    else
      return_from_service <= retReq;
  end
  // New return address per accepted vector, so each push is told apart
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pushCount   <= 0;
      return_addr <= 16'h0100;
    end
    else if (vecIn.push)
    begin
      pushCount   <= pushCount + 1;
      return_addr <= return_addr + 16'h0002;
    end
  end
endmodule

// ===== testbench/tb_top.sv
// Testbench: register access and interrupt vectoring scenarios
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_ctrl_pkg::*;
  // Bus signals
  logic        clk, srst;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  // Sources and core side
  logic        timer_overflow, port_read, periph_pending, return_from_service, retReq;
  logic [2:0]  ext_pin;
  logic [6:0]  port_pin, port_is_input, port_pullup_on;
  logic [15:0] return_addr, stack_push_data;
  vec_req_t    vec_out;
  int          pushCount;
  // Counters
  int          bad_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  two_level_interrupt_controller DUT (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .timer_overflow, .ext_pin, .port_pin, .port_read, .periph_pending,
    .port_is_input, .port_pullup_on, .return_from_service, .return_addr,
    .vec_out, .stack_push_data);
  core_model core (.clk, .srst, .vecIn(vec_out), .return_from_service,
    .return_addr, .retReq, .pushCount);
  // 20 MHz clock
  always #25 clk = ~clk;
  // Four-state compare, counted
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aT, wT, bT;
    logic [1:0] br;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    bT = 1'b0;
    while (!bT)
    begin
      // Sample mid-cycle; the transfer happens at the next rising edge
      @(negedge clk);
      aT = s_axi_awvalid && s_axi_awready;
      wT = s_axi_wvalid && s_axi_wready;
      bT = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge clk);
      if (aT)
        s_axi_awvalid <= 1'b0;
      if (wT)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", 32'h0, {30'h0, br});
  endtask
  // Read and compare data and response
  task automatic rdChk(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    logic aT, rT;
    logic [31:0] rd;
    logic [1:0] rr;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    rT = 1'b0;
    while (!rT)
    begin
      @(negedge clk);
      aT = s_axi_arvalid && s_axi_arready;
      rT = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk);
      if (aT)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk("rdata", {24'h000000, e}, rd);
    chk("rresp", {30'h0, er}, {30'h0, rr});
  endtask
  // One-cycle pulse: 0 timer, 1 port read, else return request
  task automatic pulse(input int which);
    @(posedge clk);
    case (which)
      0: timer_overflow <= 1'b1;
      1: port_read <= 1'b1;
      default: retReq <= 1'b1;
    endcase
    @(posedge clk);
    timer_overflow <= 1'b0;
    port_read      <= 1'b0;
    retReq         <= 1'b0;
  endtask
  // Cycles with no vector expected
  task automatic idle(input int n);
    int seen;
    seen = 0;
    repeat (n)
    begin
      @(negedge clk);
      if (vec_out.push === 1'b1)
        seen++;
    end
    chk("no push", 32'h0, seen);
  endtask
  // Wait for a push; check vector, level, stacked address and delay
  task automatic waitPush(input logic [15:0] v, input logic h, input int maxLat);
    int n;
    n = 0;
    // Step off the launching edge first, so a stale pulse is never taken
    do
    begin
      @(negedge clk);
      n++;
    end
    while (vec_out.push !== 1'b1 && n < 40);
    chk("push", 32'h1, {31'h0, vec_out.push});
    chk("vector", {16'h0000, v}, {16'h0000, vec_out.vector});
    chk("high", {31'h0, h}, {31'h0, vec_out.high});
    chk("stack", {16'h0000, 16'h0100 + 16'(2 * pushCount)}, {16'h0000, stack_push_data});
    chk("latency", 32'h1, {31'h0, n <= maxLat});
  endtask
  // Counts and verdict, then stop
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, far above the expected run length
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      bad_count++;
      results();
    end
  end
  // Main sequence
  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {timer_overflow, port_read, periph_pending, retReq, ext_pin, port_pin} = '0;
    port_is_input = 7'h7F;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rdChk(12'h000, 8'h00, 2'b00);
    rdChk(12'h004, 8'hF5, 2'b00);
    rdChk(12'h008, 8'hC0, 2'b00);
    rdChk(12'h100, 8'h00, 2'b10);
    wr(12'h004, 8'hFF);
    rdChk(12'h004, 8'hF5, 2'b00);
    $display("test registers done");
    wr(12'h000, 8'h80);
    pulse(0);
    idle(6);
    rdChk(12'h000, 8'h84, 2'b00);
    $display("test polling done");
    wr(12'h004, 8'hF1);
    wr(12'h000, 8'hA0);
    pulse(0);
    waitPush(16'h0008, 1'b1, 40);
    rdChk(12'h000, 8'h24, 2'b00);
    wr(12'h000, 8'h20);
    pulse(2);
    rdChk(12'h000, 8'hA0, 2'b00);
    $display("test compat timer done");
    wr(12'h000, 8'h40);
    periph_pending <= 1'b1;
    idle(8);
    wr(12'h000, 8'h80);
    idle(8);
    wr(12'h000, 8'hC0);
    waitPush(16'h0008, 1'b1, 40);
    periph_pending <= 1'b0;
    pulse(2);
    rdChk(12'h000, 8'hC0, 2'b00);
    $display("test compat peripheral done");
    wr(12'h00C, 8'h01);
    wr(12'h000, 8'hE0);
    pulse(0);
    waitPush(16'h0018, 1'b0, 40);
    rdChk(12'h000, 8'hA4, 2'b00);
    wr(12'h000, 8'hB0);
    ext_pin[0] <= 1'b1;
    waitPush(16'h0008, 1'b1, 5);
    rdChk(12'h000, 8'h32, 2'b00);
    wr(12'h000, 8'h70);
    pulse(0);
    idle(10);
    wr(12'h000, 8'h30);
    pulse(2);
    pulse(2);
    rdChk(12'h000, 8'hF0, 2'b00);
    ext_pin[0] <= 1'b0;
    $display("test preemption done");
    wr(12'h004, 8'hF5);
    wr(12'h000, 8'h00);
    pulse(0);
    periph_pending <= 1'b1;
    wr(12'h000, 8'hE4);
    waitPush(16'h0008, 1'b1, 40);
    idle(8);
    wr(12'h000, 8'h60);
    pulse(2);
    waitPush(16'h0018, 1'b0, 40);
    periph_pending <= 1'b0;
    pulse(2);
    wr(12'h00C, 8'h00);
    wr(12'h000, 8'h00);
    $display("test simultaneous done");
    wr(12'h004, 8'hD5);
    ext_pin[1] <= 1'b1;
    idle(8);
    rdChk(12'h008, 8'hC0, 2'b00);
    ext_pin[1] <= 1'b0;
    idle(8);
    rdChk(12'h008, 8'hC1, 2'b00);
    wr(12'h008, 8'hC0);
    ext_pin[2] <= 1'b1;
    idle(8);
    rdChk(12'h008, 8'hC2, 2'b00);
    $display("test edges done");
    wr(12'h010, 8'h55);
    @(negedge clk);
    chk("pullup", 32'h0, {25'h0, port_pullup_on});
    wr(12'h004, 8'h55);
    @(negedge clk);
    chk("pullup", 32'h55, {25'h0, port_pullup_on});
    @(posedge clk);
    port_is_input <= 7'h0F;
    @(negedge clk);
    chk("pullup", 32'h05, {25'h0, port_pullup_on});
    $display("test pullups done");
    wr(12'h014, 8'h01);
    pulse(1);
    wr(12'h000, 8'h00);
    port_pin[1] <= 1'b1;
    idle(8);
    rdChk(12'h000, 8'h00, 2'b00);
    port_pin[0] <= 1'b1;
    idle(8);
    rdChk(12'h000, 8'h01, 2'b00);
    wr(12'h000, 8'h00);
    rdChk(12'h000, 8'h01, 2'b00);
    pulse(1);
    wr(12'h000, 8'h00);
    rdChk(12'h000, 8'h00, 2'b00);
    $display("test port change done");
    results();
  end
endmodule
